/* File: sfspi_front_end.sv */
// Purpose: Serial interface front end of a serial flash memory, pin side to core side
// Assumes: mclk far faster than the serial clock; all pins oversampled
// Notes: Contains the receive FIFO and the top module
// Contract
// R1 - Sample input lane on serial clock rising edges
// R2 - Dual read turns input lane into output
// R3 - Shift data out on falling clock edges
// R4 - Deselected: all data outputs float
// R5 - Act only while chip select is low
// R6 - Ignore commands until first select falling edge
// R7 - Pause floats output, ignores clock and input
// R8 - Write guard and lock bits block writes
// R9 - Support clock modes 0 and 3
// R10 - Host parks clock low or high when idle
// R11 - 1 MiB array of 64 kB blocks, 4 kB sectors
// R12 - Each 256-byte page programmable alone
// R13 - Programming only clears bits to zero
// R14 - Erase by sector, block, chip; never page
// R15 - Dual output continues until select rises
// R16 - Write guard ignored during dual read
// R17 - Pause starts or ends when clock low
// R18 - Select rise discards partial command, idles
`timescale 1ns/1ps
`default_nettype none

module sfspi_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);
   localparam logic [PTR_W:0] ONE_CNT = (PTR_W+1)'(1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != FULL_CNT);
   assign out_valid = (count_reg != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         out_data <= '0;
      end else if (out_valid) begin
         if (!pop) begin
            out_data <= mem_reg[rd_ptr_reg];
         end else if (push && count_reg == ONE_CNT) begin
            // The word behind the head is being written at this very edge
            out_data <= in_data;
         end else begin
            out_data <= mem_reg[(rd_ptr_reg == LAST_IDX) ? '0 : rd_ptr_reg + 1'b1];
         end
      end else if (push) begin
         out_data <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_IDX) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_IDX) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end
endmodule : sfspi_fifo

module sfspi_front_end
   import sfspi_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = SFSPI_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic nrst,
   // Pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic data_in_lane0,
   output logic data_in_lane0_out,
   output logic data_in_lane0_oe_n,
   output logic data_out,
   output logic data_out_oe_n,
   // Received bytes toward the command core
   output sfspi_rx_t rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_overrun,
   // Read data from the command core
   input wire logic tx_active,
   input wire logic tx_dual,
   input wire logic [SFSPI_BYTE_W-1:0] tx_byte,
   output logic tx_take,
   // Frame state
   output logic selected,
   output logic paused,
   output logic frame_end,
   // Protection
   input wire logic status_lock_bit,
   input wire logic protect_range_bit0,
   input wire logic protect_range_bit1,
   input wire logic protect_range_bit2,
   input wire logic protect_range_bit3,
   output logic write_guard_low,
   output logic status_write_blocked,
   input wire logic [SFSPI_ADDR_W-1:0] check_addr,
   output logic addr_protected,
   output logic chip_erase_blocked,
   // Array organisation helpers
   input wire sfspi_erase_t erase_kind,
   input wire logic [SFSPI_ADDR_W-1:0] erase_addr,
   output sfspi_range_t erase_range,
   input wire logic [SFSPI_ADDR_W-1:0] prog_addr,
   output logic [SFSPI_ADDR_W-1:0] prog_addr_next,
   input wire logic [SFSPI_BYTE_W-1:0] prog_old,
   input wire logic [SFSPI_BYTE_W-1:0] prog_new,
   output logic [SFSPI_BYTE_W-1:0] prog_result
);
   typedef enum logic [1:0] {
      SFSPI_IDLE,
      SFSPI_ACTIVE,
      SFSPI_HOLD
   } sfspi_state_t;

   logic [SFSPI_SYNC_W-1:0] meta_reg;
   logic [SFSPI_SYNC_W-1:0] sync_reg;
   logic sck_prev_reg;
   logic cs_prev_reg;
   logic armed_reg;
   logic [1:0] fill_reg;
   logic seen_high_reg;
   logic arm_fall;
   sfspi_state_t state_reg;
   logic [SFSPI_BYTE_W-1:0] rx_shift_reg;
   logic [2:0] rx_cnt_reg;
   logic first_reg;
   logic [SFSPI_BYTE_W-1:0] tx_shift_reg;
   logic [2:0] tx_cnt_reg;
   logic tx_loaded_reg;
   logic dual_reg;
   logic drive_reg;
   logic rx_push;
   logic in_ready;
   sfspi_rx_t rx_word;
   logic sck_s;
   logic cs_s;
   logic hold_s;
   logic din_s;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic live;
   logic [SFSPI_PROT_W-1:0] prot;
   logic [SFSPI_BLKIDX_W:0] prot_first_block;
   logic [2:0] tx_step;

   // Every pin input crosses two flops; edges come from the second stage only
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         meta_reg <= SFSPI_SYNC_IDLE;
         sync_reg <= SFSPI_SYNC_IDLE;
      end else begin
         meta_reg <= {wp_n, data_in_lane0, hold_n, cs_n, sck};
         sync_reg <= meta_reg;
      end
   end

   assign sck_s = sync_reg[SFSPI_SYN_SCK];
   assign cs_s = sync_reg[SFSPI_SYN_CS];
   assign hold_s = sync_reg[SFSPI_SYN_HOLD];
   assign din_s = sync_reg[SFSPI_SYN_DIN];
   assign write_guard_low = ~sync_reg[SFSPI_SYN_WP];

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sck_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end else begin
         sck_prev_reg <= sck_s;
         cs_prev_reg <= cs_s;
      end
   end

   // Either idle clock level works: only edges matter, never the park level
   assign sck_rise = sck_s && !sck_prev_reg; // R9
   assign sck_fall = !sck_s && sck_prev_reg; // R9
   assign cs_fall = !cs_s && cs_prev_reg;
   assign cs_rise = cs_s && !cs_prev_reg;
   assign frame_end = cs_rise;

   // The synchroniser shows its reset pattern for two edges, so a high select then is not real
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         fill_reg <= 2'h0;
         seen_high_reg <= 1'b0;
      end else begin
         fill_reg <= {fill_reg[0], 1'b1};
         if (fill_reg[1] && cs_s) begin
            seen_high_reg <= 1'b1; // R6
         end
      end
   end

   assign arm_fall = cs_fall && seen_high_reg; // R6

   // Power-up needs one real select falling edge; a select already low is not trusted
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         armed_reg <= 1'b0;
      end else if (arm_fall) begin
         armed_reg <= 1'b1; // R6
      end
   end

   // Pause enters and returns to active only while the clock sits low; a select rise ends it at any clock level
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_reg <= SFSPI_IDLE;
      end else begin
         unique case (state_reg)
            SFSPI_IDLE: begin
               if (arm_fall || (!cs_s && armed_reg)) begin
                  state_reg <= SFSPI_ACTIVE; // R5 R6
               end
            end
            SFSPI_ACTIVE: begin
               if (cs_s) begin
                  state_reg <= SFSPI_IDLE; // R18
               end else if (!hold_s && !sck_s) begin
                  state_reg <= SFSPI_HOLD; // R17
               end
            end
            SFSPI_HOLD: begin
               if (cs_s) begin
                  state_reg <= SFSPI_IDLE; // R18
               end else if (hold_s && !sck_s) begin
                  state_reg <= SFSPI_ACTIVE; // R17
               end
            end
         endcase
      end
   end

   assign selected = !cs_s && (state_reg != SFSPI_IDLE); // R4
   assign paused = (state_reg == SFSPI_HOLD);
   assign live = !cs_s && (state_reg == SFSPI_ACTIVE); // R5 R7

   // Receive shifter; an incomplete byte dies with the frame
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rx_shift_reg <= SFSPI_BYTE_ZERO;
         rx_cnt_reg <= '0;
         first_reg <= 1'b1;
      end else if (!live && state_reg != SFSPI_HOLD) begin
         rx_cnt_reg <= '0; // R18
         first_reg <= 1'b1; // R18
      end else if (live && sck_rise && !dual_reg) begin
         rx_shift_reg <= {rx_shift_reg[SFSPI_BYTE_W-2:0], din_s}; // R1
         rx_cnt_reg <= rx_cnt_reg + SFSPI_STEP_SINGLE;
         if (rx_cnt_reg == SFSPI_LAST_BIT) begin
            first_reg <= 1'b0;
         end
      end
   end

   assign rx_push = live && sck_rise && !dual_reg && (rx_cnt_reg == SFSPI_LAST_BIT); // R1
   assign rx_word.first = first_reg;
   assign rx_word.data = {rx_shift_reg[SFSPI_BYTE_W-2:0], din_s};

   // The link cannot stall, so a full FIFO drops the byte and reports it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rx_overrun <= 1'b0;
      end else if (rx_push && !in_ready) begin
         rx_overrun <= 1'b1;
      end else if (cs_fall) begin
         rx_overrun <= 1'b0;
      end
   end

   sfspi_fifo #(
      .WIDTH($bits(sfspi_rx_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_data(rx_word),
      .in_valid(rx_push),
      .in_ready(in_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   // Dual latches at the first output edge and holds until select rises
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dual_reg <= 1'b0;
      end else if (cs_s) begin
         dual_reg <= 1'b0; // R15 R18
      end else if (live && sck_fall && tx_active && tx_dual) begin
         dual_reg <= 1'b1; // R2 R15
      end
   end

   assign tx_step = (dual_reg || tx_dual) ? SFSPI_STEP_DUAL : SFSPI_STEP_SINGLE;
   assign tx_take = live && sck_fall && (tx_active || dual_reg) &&
                    (!tx_loaded_reg || (tx_cnt_reg + tx_step == '0));

   // Output shifter moves only on falling edges, so bits settle before the host samples
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_shift_reg <= SFSPI_BYTE_ZERO;
         tx_cnt_reg <= '0;
         tx_loaded_reg <= 1'b0;
         drive_reg <= 1'b0;
      end else if (cs_s) begin
         tx_cnt_reg <= '0; // R18
         tx_loaded_reg <= 1'b0;
         drive_reg <= 1'b0;
      end else if (tx_take) begin
         tx_shift_reg <= tx_byte; // R3
         tx_cnt_reg <= '0;
         tx_loaded_reg <= 1'b1;
         drive_reg <= 1'b1;
      end else if (live && sck_fall && tx_loaded_reg) begin
         tx_shift_reg <= (dual_reg) ? {tx_shift_reg[SFSPI_BYTE_W-3:0], 2'h0}
                                    : {tx_shift_reg[SFSPI_BYTE_W-2:0], 1'b0}; // R3 R2
         tx_cnt_reg <= tx_cnt_reg + tx_step;
      end else if (live && sck_fall && !tx_active) begin
         drive_reg <= 1'b0;
      end
   end

   // Upper bit leads on the normal pin, the next bit on the input lane in dual mode
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         data_out <= 1'b0;
         data_in_lane0_out <= 1'b0;
         data_out_oe_n <= 1'b1;
         data_in_lane0_oe_n <= 1'b1;
      end else begin
         data_out <= tx_shift_reg[SFSPI_BYTE_W-1]; // R3
         data_in_lane0_out <= tx_shift_reg[SFSPI_BYTE_W-2]; // R2
         data_out_oe_n <= !(live && drive_reg); // R4 R7
         data_in_lane0_oe_n <= !(live && drive_reg && dual_reg); // R2 R4 R7 R15
      end
   end

   // Protection: the guard pin only matters with the lock bit, and never in dual reads
   assign prot = {protect_range_bit3, protect_range_bit2, protect_range_bit1, protect_range_bit0};
   assign status_write_blocked = status_lock_bit && write_guard_low && !dual_reg; // R8 R16
   assign chip_erase_blocked = (prot != SFSPI_PROT_NONE); // R8

   // Top-down protection doubles with each code; codes past the array protect it all
   always_comb begin
      if (prot == SFSPI_PROT_NONE) begin
         prot_first_block = SFSPI_BLOCKS_TOP;
      end else if (prot >= SFSPI_PROT_ALL) begin
         prot_first_block = '0;
      end else begin
         prot_first_block = SFSPI_BLOCKS_TOP -
                            (SFSPI_BLKIDX_W+1)'(1 << (prot - SFSPI_PROT_W'(1)));
      end
   end

   assign addr_protected = ({1'b0, check_addr[SFSPI_ADDR_W-1:SFSPI_BLOCK_W]} >=
                            prot_first_block); // R8 R11

   // Erase ranges exist only at sector, block and chip size
   always_comb begin
      erase_range.base = '0;
      erase_range.last = SFSPI_ADDR_W'(SFSPI_ARRAY_BYTES - 1); // R11
      unique case (erase_kind)
         SFSPI_ERASE_SECTOR: begin
            erase_range.base = {erase_addr[SFSPI_ADDR_W-1:SFSPI_SECTOR_W],
                                {SFSPI_SECTOR_W{1'b0}}}; // R14
            erase_range.last = {erase_addr[SFSPI_ADDR_W-1:SFSPI_SECTOR_W],
                                {SFSPI_SECTOR_W{1'b1}}}; // R14
         end
         SFSPI_ERASE_BLOCK: begin
            erase_range.base = {erase_addr[SFSPI_ADDR_W-1:SFSPI_BLOCK_W],
                                {SFSPI_BLOCK_W{1'b0}}}; // R14
            erase_range.last = {erase_addr[SFSPI_ADDR_W-1:SFSPI_BLOCK_W],
                                {SFSPI_BLOCK_W{1'b1}}}; // R14
         end
         SFSPI_ERASE_CHIP: begin
            erase_range.base = '0; // R14
         end
         default: begin
            erase_range.base = '0;
         end
      endcase
   end

   // Program addressing wraps inside the page so a page stays independent
   assign prog_addr_next = {prog_addr[SFSPI_ADDR_W-1:SFSPI_PAGE_W],
                            prog_addr[SFSPI_PAGE_W-1:0] + SFSPI_PAGE_W'(1)}; // R12
   assign prog_result = prog_old & prog_new; // R13
endmodule : sfspi_front_end

`default_nettype wire

/* File: sfspi_pkg.sv */
// Purpose: Shared constants and types of the serial flash interface front end
// Assumes: Byte-addressed array of 1 MiB, uniform blocks and sectors
// Notes: Imported whole by the front end
package sfspi_pkg;
   localparam int unsigned SFSPI_ADDR_W = 20;
   localparam int unsigned SFSPI_BYTE_W = 8;
   localparam int unsigned SFSPI_ARRAY_BYTES = 1048576;
   localparam int unsigned SFSPI_PAGE_W = 8;
   localparam int unsigned SFSPI_SECTOR_W = 12;
   localparam int unsigned SFSPI_BLOCK_W = 16;
   localparam int unsigned SFSPI_BLOCK_CNT = SFSPI_ARRAY_BYTES >> SFSPI_BLOCK_W;
   localparam int unsigned SFSPI_BLKIDX_W = SFSPI_ADDR_W - SFSPI_BLOCK_W;
   localparam int unsigned SFSPI_PROT_W = 4;
   localparam int unsigned SFSPI_SYNC_W = 5;
   localparam int unsigned SFSPI_FIFO_DEPTH = 8;
   localparam logic [2:0] SFSPI_LAST_BIT = 3'h7;
   localparam logic [2:0] SFSPI_STEP_SINGLE = 3'h1;
   localparam logic [2:0] SFSPI_STEP_DUAL = 3'h2;
   localparam logic [SFSPI_BYTE_W-1:0] SFSPI_ERASED = 8'hFF;
   localparam logic [SFSPI_BYTE_W-1:0] SFSPI_BYTE_ZERO = 8'h00;
   localparam logic [SFSPI_PROT_W-1:0] SFSPI_PROT_NONE = 4'h0;
   localparam logic [SFSPI_PROT_W-1:0] SFSPI_PROT_ALL = 4'h5;
   localparam logic [SFSPI_BLKIDX_W:0] SFSPI_BLOCKS_TOP = 5'h10;
   // Synchroniser lane positions
   localparam int unsigned SFSPI_SYN_SCK = 0;
   localparam int unsigned SFSPI_SYN_CS = 1;
   localparam int unsigned SFSPI_SYN_HOLD = 2;
   localparam int unsigned SFSPI_SYN_DIN = 3;
   localparam int unsigned SFSPI_SYN_WP = 4;
   localparam logic [SFSPI_SYNC_W-1:0] SFSPI_SYNC_IDLE = 5'h16;

   typedef enum logic [1:0] {
      SFSPI_ERASE_SECTOR,
      SFSPI_ERASE_BLOCK,
      SFSPI_ERASE_CHIP
   } sfspi_erase_t;

   typedef struct packed {
      logic first;
      logic [SFSPI_BYTE_W-1:0] data;
   } sfspi_rx_t;

   typedef struct packed {
      logic [SFSPI_ADDR_W-1:0] base;
      logic [SFSPI_ADDR_W-1:0] last;
   } sfspi_range_t;
endpackage : sfspi_pkg

/* File: sfspi_front_end_properties.sv */
// Purpose: Port-level properties of the flash serial front end
// Assumes: One mclk domain, nrst synchronous and active low
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module sfspi_front_end_properties (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic status_lock_bit,
   input wire logic data_out,
   input wire logic data_out_oe_n,
   input wire logic data_in_lane0_oe_n,
   input wire logic tx_take,
   input wire logic selected,
   input wire logic frame_end,
   input wire logic write_guard_low,
   input wire logic status_write_blocked,
   input wire logic [7:0] prog_old,
   input wire logic [7:0] prog_new,
   input wire logic [7:0] prog_result
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // Five samples cover the two-flop synchroniser and the output register
   sequence s_desel;
      cs_n [*5];
   endsequence
   sequence s_hold;
      (!cs_n && !hold_n && !sck) [*6];
   endsequence
   property p_float;
      s_desel |-> data_out_oe_n && data_in_lane0_oe_n;
   endproperty
   a_float: assert property (p_float) else $error("output driven while deselected");
   property p_pause;
      s_hold |-> data_out_oe_n;
   endproperty
   a_pause: assert property (p_pause) else $error("output driven in pause");
   property p_no_take;
      s_desel |-> !tx_take;
   endproperty
   a_no_take: assert property (p_no_take) else $error("byte taken while deselected");
   property p_end;
      selected && $rose(cs_n) |-> ##[1:5] frame_end;
   endproperty
   a_end: assert property (p_end) else $error("no frame end after select rise");
   property p_idle;
      frame_end |-> ##[0:2] !selected;
   endproperty
   a_idle: assert property (p_idle) else $error("frame stays open after end");
   property p_block;
      status_write_blocked |-> status_lock_bit && write_guard_low;
   endproperty
   a_block: assert property (p_block) else $error("status write blocked without cause");
   property p_guard;
      write_guard_low == !$past(wp_n, 2);
   endproperty
   a_guard: assert property (p_guard) else $error("write guard not the synced pin");
   property p_prog;
      prog_result == (prog_old & prog_new);
   endproperty
   a_prog: assert property (p_prog) else $error("programming set a bit");
   property p_edge;
      $changed(data_out) && !data_out_oe_n && !$past(data_out_oe_n)
         |-> !sck && !$past(sck, 3);
   endproperty
   a_edge: assert property (p_edge) else $error("output changed away from falling edge");
endmodule : sfspi_front_end_properties
`default_nettype wire

/* File: sfspi_host_model.sv */
// Purpose: Bus master model that clocks bytes in and out of the front end
// Assumes: Half period of 16 mclk, changes 1 ns after an mclk edge
// Notes: Released lane toggles each clock so stale levels never pass as data
`timescale 1ns/1ps
`default_nettype none
module sfspi_host_model (
   input wire logic mclk,
   input wire logic data_out,
   input wire logic data_out_oe_n,
   input wire logic lane0,
   input wire logic lane0_oe_n,
   output logic sck,
   output logic cs_n,
   output logic mosi
);
   logic idle = 1'b0;
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      mosi = 1'b0;
   end
   task automatic half();
      repeat (16) @(posedge mclk);
      #1;
   endtask : half
   task automatic park(input logic v);
      sck = v;
      half();
   endtask : park
   task automatic sel(input logic mode3);
      idle = mode3;
      park(mode3);
      cs_n = 1'b0;
      half();
   endtask : sel
   task automatic desel();
      park(idle);
      cs_n = 1'b1;
      half();
   endtask : desel
   task automatic xfer(input logic [7:0] tx, input int nb, input logic dual,
         output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb; i -= (dual ? 2 : 1)) begin
         sck = 1'b0;
         mosi = dual ? ~mosi : tx[i];
         half();
         sck = 1'b1;
         rx[i] = data_out_oe_n ? 1'bx : data_out;
         if (dual) begin
            rx[i-1] = lane0_oe_n ? 1'bx : lane0;
         end
         half();
      end
   endtask : xfer
endmodule : sfspi_host_model
`default_nettype wire

/* File: tb_sfspi_front_end.sv */
// Purpose: Self-checking bench of the flash serial front end
// Assumes: mclk 200 MHz, serial clock 160 ns from the host model
// Notes: Core side driven by hand, one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_sfspi_front_end;
   import sfspi_pkg::*;
   logic mclk, nrst, hold_n, wp_n, rx_ready, tx_active, tx_dual, lock;
   logic [3:0] prot;
   logic [7:0] tx_byte, p_old, p_new, p_res, rd;
   logic [19:0] c_addr, e_addr, p_addr, p_next;
   sfspi_erase_t e_kind;
   sfspi_range_t e_range;
   sfspi_rx_t rx_data;
   logic sck, cs_n, mosi, lane, lane_out, lane_oe_n, dout, dout_oe_n;
   logic rx_valid, rx_overrun, tx_take, selected, paused, frame_end;
   logic wg_low, sw_blk, a_prot, ce_blk;
   int bad_count = 0;
   int check_count = 0;
   int takes = 0;
   localparam logic [39:0] ER [3] = '{40'h12000_12FFF, 40'h10000_1FFFF, 40'h00000_FFFFF};
   assign lane = lane_oe_n ? mosi : lane_out;
   sfspi_front_end dut_u (.mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n),
      .hold_n(hold_n), .wp_n(wp_n), .data_in_lane0(lane), .data_in_lane0_out(lane_out),
      .data_in_lane0_oe_n(lane_oe_n), .data_out(dout), .data_out_oe_n(dout_oe_n),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
      .tx_active(tx_active), .tx_dual(tx_dual), .tx_byte(tx_byte), .tx_take(tx_take),
      .selected(selected), .paused(paused), .frame_end(frame_end),
      .status_lock_bit(lock), .protect_range_bit0(prot[0]), .protect_range_bit1(prot[1]),
      .protect_range_bit2(prot[2]), .protect_range_bit3(prot[3]),
      .write_guard_low(wg_low), .status_write_blocked(sw_blk), .check_addr(c_addr),
      .addr_protected(a_prot), .chip_erase_blocked(ce_blk), .erase_kind(e_kind),
      .erase_addr(e_addr), .erase_range(e_range), .prog_addr(p_addr),
      .prog_addr_next(p_next), .prog_old(p_old), .prog_new(p_new), .prog_result(p_res));
   sfspi_host_model host_u (.mclk(mclk), .data_out(dout), .data_out_oe_n(dout_oe_n),
      .lane0(lane_out), .lane0_oe_n(lane_oe_n), .sck(sck), .cs_n(cs_n), .mosi(mosi));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) if (tx_take === 1'b1) takes <= takes + 1;
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Head is checked with the stall held, then popped for one cycle
   task automatic pop(input logic [8:0] exp);
      for (int k = 0; k < 600 && rx_valid !== 1'b1; k++) cyc(1);
      chk(rx_valid, 1);
      chk(rx_data, exp);
      rx_ready = 1'b1;
      cyc(1);
      rx_ready = 1'b0;
   endtask : pop
   task automatic flush();
      rx_ready = 1'b1;
      cyc(12);
      rx_ready = 1'b0;
   endtask : flush
   task automatic t_unarmed();
      host_u.xfer(8'hA5, 8, 1'b0, rd);
      cyc(4);
      chk(rx_valid, 0);
      chk(selected, 0);
      host_u.desel();
   endtask : t_unarmed
   task automatic t_rx();
      for (int m = 0; m < 2; m++) begin
         host_u.sel(m[0]);
         host_u.xfer(m ? 8'hC3 : 8'h5A, 8, 1'b0, rd);
         host_u.xfer(8'h81, 8, 1'b0, rd);
         host_u.desel();
         pop({1'b1, m ? 8'hC3 : 8'h5A});
         pop({1'b0, 8'h81});
      end
   endtask : t_rx
   task automatic t_fifo();
      host_u.sel(1'b0);
      for (int i = 0; i < 9; i++) host_u.xfer({i[3:0], ~i[3:0]}, 8, 1'b0, rd);
      chk(rx_overrun, 1);
      host_u.desel();
      for (int i = 0; i < 8; i++) pop({i == 0, i[3:0], ~i[3:0]});
      chk(rx_valid, 0);
   endtask : t_fifo
   task automatic t_read();
      host_u.sel(1'b0);
      host_u.xfer(8'h03, 8, 1'b0, rd);
      tx_active = 1'b1;
      tx_byte = 8'hB4;
      host_u.xfer(8'h00, 8, 1'b0, rd);
      chk(rd, 8'hB4);
      host_u.desel();
      chk({dout_oe_n, lane_oe_n}, 2'b11);
      tx_active = 1'b0;
      flush();
   endtask : t_read
   task automatic t_dual();
      lock = 1'b1;
      wp_n = 1'b0;
      host_u.sel(1'b0);
      host_u.xfer(8'h3B, 8, 1'b0, rd);
      tx_active = 1'b1;
      tx_dual = 1'b1;
      tx_byte = 8'h96;
      for (int i = 0; i < 2; i++) begin
         host_u.xfer(8'h00, 8, 1'b1, rd);
         chk(rd, 8'h96);
      end
      chk(sw_blk, 0);
      host_u.desel();
      tx_active = 1'b0;
      tx_dual = 1'b0;
      cyc(4);
      chk(sw_blk, 1);
      lock = 1'b0;
      cyc(1);
      chk(sw_blk, 0);
      wp_n = 1'b1;
      flush();
   endtask : t_dual
   task automatic t_pause();
      int t0;
      host_u.sel(1'b0);
      host_u.xfer(8'h03, 8, 1'b0, rd);
      tx_active = 1'b1;
      host_u.xfer(8'h00, 8, 1'b0, rd);
      flush();
      hold_n = 1'b0;
      cyc(8);
      chk(paused, 0);
      host_u.park(1'b0);
      chk(paused, 1);
      chk(dout_oe_n, 1);
      t0 = takes;
      host_u.xfer(8'hE7, 8, 1'b0, rd);
      host_u.park(1'b0);
      chk(takes - t0, 0);
      hold_n = 1'b1;
      cyc(8);
      chk(paused, 0);
      host_u.desel();
      tx_active = 1'b0;
      chk(rx_valid, 0);
   endtask : t_pause
   task automatic t_abort();
      host_u.sel(1'b0);
      host_u.xfer(8'hF0, 4, 1'b0, rd);
      host_u.desel();
      chk(rx_valid, 0);
      host_u.sel(1'b0);
      host_u.xfer(8'h69, 8, 1'b0, rd);
      host_u.desel();
      pop({1'b1, 8'h69});
   endtask : t_abort
   task automatic t_helpers();
      e_addr = 20'h12345;
      p_addr = 20'h123FF;
      p_old = 8'hAA;
      p_new = 8'h0F;
      for (int k = 0; k < 3; k++) begin
         e_kind = sfspi_erase_t'(k);
         cyc(1);
         chk(e_range, ER[k]);
      end
      chk(p_next, 20'h12300);
      chk(p_res, 8'h0A);
      prot = 4'h1;
      c_addr = 20'hF0000;
      cyc(1);
      chk({a_prot, ce_blk}, 2'b11);
      prot = 4'h3;
      c_addr = 20'hBFFFF;
      cyc(1);
      chk(a_prot, 0);
      prot = 4'h0;
      cyc(1);
      chk({a_prot, ce_blk}, 2'b00);
      prot = 4'h5;
      c_addr = 20'h00000;
      cyc(1);
      chk(a_prot, 1);
      prot = 4'h0;
   endtask : t_helpers
   task automatic conclude();
      $display("checks=%0d bad=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   initial begin
      nrst = 1'b0;
      hold_n = 1'b1;
      wp_n = 1'b1;
      rx_ready = 1'b0;
      tx_active = 1'b0;
      tx_dual = 1'b0;
      lock = 1'b0;
      prot = 4'h0;
      tx_byte = 8'h00;
      p_old = 8'h00;
      p_new = 8'h00;
      c_addr = 20'h0;
      e_addr = 20'h0;
      p_addr = 20'h0;
      e_kind = SFSPI_ERASE_SECTOR;
      cyc(16);
      nrst = 1'b1;
      cyc(3);
      t_unarmed();
      t_rx();
      t_fifo();
      t_read();
      t_dual();
      t_pause();
      t_abort();
      t_helpers();
      conclude();
   end
   // Whole run needs about 6.5k cycles; 60k means a hang
   initial begin
      #300000;
      bad_count++;
      conclude();
   end
endmodule : tb_sfspi_front_end
bind sfspi_front_end sfspi_front_end_properties chk_u (.mclk(mclk), .nrst(nrst),
   .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n), .status_lock_bit(status_lock_bit),
   .data_out(data_out), .data_out_oe_n(data_out_oe_n),
   .data_in_lane0_oe_n(data_in_lane0_oe_n), .tx_take(tx_take), .selected(selected),
   .frame_end(frame_end), .write_guard_low(write_guard_low),
   .status_write_blocked(status_write_blocked), .prog_old(prog_old),
   .prog_new(prog_new), .prog_result(prog_result));
`default_nettype wire
